//--- fsc_pkg.sv
// Constants, field layout and reset values for the synthesizer config bank.
// Assumes a single register clock domain and APB access with 32-bit data.
//
// Contract
// - A 0-to-1 change of the calibration bit starts exactly one calibration.
// - Divider sync bit high holds the synthesizer's output dividers synced.
// - Doubler bit selects reference divider output (0) or doubled reference.
// - Loop mode 00 single, 01 cascaded, 10 fixed delay; 11 reserved.
// - Modulator power-down bit high powers it down; resets to 1.
// - Full eight-bit pump current code, 4 uA per step, resets to 0x8D.
// - Bits 7:6 give the second-pole resistor code, reset 0x3.
// - Bits 5:3 give the zero resistor code, reset 0x5.
// - Bits 2:0 give the first-pole capacitor code, reset 0x0.
`default_nettype none

package fsc_pkg;

  // Byte address width of the register port
  localparam int unsigned ADDR_W = 12;

  // Register indexes; the byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h100;
  localparam logic [9:0] IDX_LOOP = 10'h101;
  localparam logic [9:0] IDX_PUMP = 10'h102;
  localparam logic [9:0] IDX_FILT = 10'h103;
  localparam logic [9:0] IDX_STAT = 10'h1F0;

  // Control register fields
  localparam int unsigned CTRL_CAL = 3;
  localparam int unsigned CTRL_SYNC = 2;
  localparam int unsigned CTRL_PD = 1;
  localparam int unsigned CTRL_RST = 0;
  localparam logic [7:0] CTRL_MASK = 8'h0F;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Loop configuration register fields
  localparam int unsigned LOOP_DBL = 3;
  localparam int unsigned LOOP_MODE_HI = 2;
  localparam int unsigned LOOP_MODE_LO = 1;
  localparam int unsigned LOOP_MDM_PD = 0;
  localparam logic [7:0] LOOP_MASK = 8'h0F;
  localparam logic [7:0] LOOP_RESET = 8'h01;

  // Pump current code; one step is this many microamps
  localparam logic [7:0] PUMP_RESET = 8'h8D;
  localparam int unsigned PUMP_STEP_UA = 4;

  // Loop filter code fields
  localparam int unsigned FILT_RP2_HI = 7;
  localparam int unsigned FILT_RP2_LO = 6;
  localparam int unsigned FILT_RZ_HI = 5;
  localparam int unsigned FILT_RZ_LO = 3;
  localparam int unsigned FILT_CP1_HI = 2;
  localparam int unsigned FILT_CP1_LO = 0;
  localparam logic [1:0] RP2_RESET = 2'h3;
  localparam logic [2:0] RZ_RESET = 3'h5;
  localparam logic [2:0] CP1_RESET = 3'h0;
  localparam logic [7:0] FILT_RESET = {RP2_RESET, RZ_RESET, CP1_RESET};

  // Feedback path selections
  typedef enum logic [1:0] {
    FSC_MODE_SINGLE = 2'h0,
    FSC_MODE_CASCADE = 2'h1,
    FSC_MODE_FIXED_DELAY = 2'h2,
    FSC_MODE_RESERVED = 2'h3
  } fsc_loop_mode_t;

  // True when a byte address selects the register of the given index
  function automatic logic fsc_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [9:0] idx);
    fsc_hit = (addr == {idx, 2'h0});
  endfunction

endpackage

`default_nettype wire

//--- fsc_apb_port.sv
// APB answer timing: registered ready and error for every transfer.
// Assumes the master follows APB setup and access phases on pclk.
`default_nettype none

module fsc_apb_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic addr_ok,
  output logic pready,
  output logic pslverr,
  output logic setup,
  output logic done
);

  typedef struct packed {
    logic ready;
    logic err;
  } fsc_port_state_t;

  fsc_port_state_t st;
  fsc_port_state_t next_st;

  // Ready rises after the setup edge and drops once the access completes
  always_comb begin
    next_st.ready = psel & ~(penable & st.ready);
    next_st.err = psel & ~(penable & st.ready) & ~addr_ok;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pready = st.ready;
  assign pslverr = st.err;
  assign setup = psel & ~penable;
  assign done = psel & penable & st.ready;

endmodule

`default_nettype wire

//--- fsc_rise_pulse.sv
// One-cycle pulse on each low-to-high change of a same-clock level.
// Assumes the level comes from a register on pclk, so no synchroniser.
`default_nettype none

module fsc_rise_pulse (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic pulse
);

  typedef struct packed {
    logic prev;
    logic pulse;
  } fsc_rise_state_t;

  fsc_rise_state_t st;
  fsc_rise_state_t next_st;

  // Only a fresh rise fires; a held level gives nothing more
  always_comb begin
    next_st.prev = level;
    next_st.pulse = level & ~st.prev;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;

endmodule

`default_nettype wire

//--- fsc_synth_cfg.sv
// Configuration and control register bank of the fractional synthesizer.
// Assumes an APB master on pclk; decoded fields feed the analog loop core.
//
// Our own choice: the APB slave port.
`default_nettype none

module fsc_synth_cfg (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic cal_start,
  output logic divider_sync,
  output logic synth_powerdown,
  output logic synth_reset,
  output logic doubler_sel,
  output logic [1:0] loop_mode,
  output logic modulator_powerdown,
  output logic [7:0] pump_current,
  output logic [1:0] second_pole_resistor,
  output logic [2:0] zero_resistor,
  output logic [2:0] first_pole_capacitor
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] loop;
    logic [7:0] pump;
    logic [7:0] filt;
    logic [7:0] cal_count;
    logic [31:0] rdata;
  } fsc_state_t;

  fsc_state_t st;
  fsc_state_t next_st;

  logic hit_ctrl;
  logic hit_loop;
  logic hit_pump;
  logic hit_filt;
  logic hit_stat;
  logic addr_ok;
  logic setup;
  logic done;
  logic wr_any;
  logic wr_ctrl;
  logic wr_loop;
  logic wr_pump;
  logic wr_filt;
  logic [7:0] rd_byte;
  logic [1:0] new_mode;

  // Address decode
  assign hit_ctrl = fsc_pkg::fsc_hit(paddr, fsc_pkg::IDX_CTRL);
  assign hit_loop = fsc_pkg::fsc_hit(paddr, fsc_pkg::IDX_LOOP);
  assign hit_pump = fsc_pkg::fsc_hit(paddr, fsc_pkg::IDX_PUMP);
  assign hit_filt = fsc_pkg::fsc_hit(paddr, fsc_pkg::IDX_FILT);
  assign hit_stat = fsc_pkg::fsc_hit(paddr, fsc_pkg::IDX_STAT);
  assign addr_ok = hit_ctrl | hit_loop | hit_pump | hit_filt | hit_stat;

  // Bus timing and error answer
  fsc_apb_port u_port (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .addr_ok(addr_ok),
    .pready(pready),
    .pslverr(pslverr),
    .setup(setup),
    .done(done)
  );

  // Write strobes take effect only at the completing edge, lane 0 only
  assign wr_any = done & pwrite & pstrb[0];
  assign wr_ctrl = wr_any & hit_ctrl;
  assign wr_loop = wr_any & hit_loop;
  assign wr_pump = wr_any & hit_pump;
  assign wr_filt = wr_any & hit_filt;
  assign new_mode = pwdata[fsc_pkg::LOOP_MODE_HI:fsc_pkg::LOOP_MODE_LO];

  // Read data selection; reserved bits come back as zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_ctrl) begin
      rd_byte = st.ctrl & fsc_pkg::CTRL_MASK;
    end else if (hit_loop) begin
      rd_byte = st.loop & fsc_pkg::LOOP_MASK;
    end else if (hit_pump) begin
      rd_byte = st.pump;
    end else if (hit_filt) begin
      rd_byte = st.filt;
    end else if (hit_stat) begin
      rd_byte = st.cal_count;
    end
  end

  // Next register contents
  always_comb begin
    next_st = st;
    if (wr_ctrl) begin
      next_st.ctrl = pwdata[7:0] & fsc_pkg::CTRL_MASK;
    end
    if (wr_loop) begin
      next_st.loop = pwdata[7:0] & fsc_pkg::LOOP_MASK;
      // A reserved mode code leaves the present path in place
      if (new_mode == fsc_pkg::FSC_MODE_RESERVED) begin
        next_st.loop[fsc_pkg::LOOP_MODE_HI:fsc_pkg::LOOP_MODE_LO] =
          st.loop[fsc_pkg::LOOP_MODE_HI:fsc_pkg::LOOP_MODE_LO];
      end
    end
    if (wr_pump) begin
      next_st.pump = pwdata[7:0];
    end
    if (wr_filt) begin
      next_st.filt = pwdata[7:0];
    end
    // Count of started calibrations, wraps at 255
    if (cal_start) begin
      next_st.cal_count = st.cal_count + 8'h01;
    end
    // Read data is loaded in setup and cleared after the access
    if (setup) begin
      next_st.rdata = {24'h000000, pwrite ? 8'h00 : rd_byte};
    end else if (done) begin
      next_st.rdata = 32'h00000000;
    end
  end

  // State register with documented reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.ctrl <= fsc_pkg::CTRL_RESET;
      st.loop <= fsc_pkg::LOOP_RESET;
      st.pump <= fsc_pkg::PUMP_RESET;
      st.filt <= fsc_pkg::FILT_RESET;
      st.cal_count <= 8'h00;
      st.rdata <= 32'h00000000;
    end else begin
      st <= next_st;
    end
  end

  // Calibration trigger from the control bit's rising change
  fsc_rise_pulse u_cal (
    .pclk(pclk),
    .presetn(presetn),
    .level(st.ctrl[fsc_pkg::CTRL_CAL]),
    .pulse(cal_start)
  );

  // Decoded controls to the analog core
  assign prdata = st.rdata;
  assign divider_sync = st.ctrl[fsc_pkg::CTRL_SYNC];
  assign synth_powerdown = st.ctrl[fsc_pkg::CTRL_PD];
  assign synth_reset = st.ctrl[fsc_pkg::CTRL_RST];
  assign doubler_sel = st.loop[fsc_pkg::LOOP_DBL];
  assign loop_mode =
    st.loop[fsc_pkg::LOOP_MODE_HI:fsc_pkg::LOOP_MODE_LO];
  assign modulator_powerdown = st.loop[fsc_pkg::LOOP_MDM_PD];
  assign pump_current = st.pump;
  assign second_pole_resistor =
    st.filt[fsc_pkg::FILT_RP2_HI:fsc_pkg::FILT_RP2_LO];
  assign zero_resistor =
    st.filt[fsc_pkg::FILT_RZ_HI:fsc_pkg::FILT_RZ_LO];
  assign first_pole_capacitor =
    st.filt[fsc_pkg::FILT_CP1_HI:fsc_pkg::FILT_CP1_LO];

  // Checks on the register bank
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_cal_rise;
    $rose(st.ctrl[fsc_pkg::CTRL_CAL]) |=> cal_start ##1 !cal_start;
  endproperty
  a_cal_rise: assert property (p_cal_rise)
    else $error("calibration rise did not give one pulse");

  property p_cal_hold;
    st.ctrl[fsc_pkg::CTRL_CAL] && $past(st.ctrl[fsc_pkg::CTRL_CAL]) &&
      $past(st.ctrl[fsc_pkg::CTRL_CAL], 2) |-> !cal_start;
  endproperty
  a_cal_hold: assert property (p_cal_hold)
    else $error("held calibration bit started another calibration");

  property p_sync;
    wr_ctrl |=> divider_sync == $past(pwdata[fsc_pkg::CTRL_SYNC]);
  endproperty
  a_sync: assert property (p_sync)
    else $error("divider sync does not follow write");

  property p_dbl;
    wr_loop |=> doubler_sel == $past(pwdata[fsc_pkg::LOOP_DBL]);
  endproperty
  a_dbl: assert property (p_dbl)
    else $error("doubler select does not follow write");

  property p_mode;
    wr_loop |=> (loop_mode == ($past(new_mode) == 2'h3 ?
      $past(loop_mode) : $past(new_mode)));
  endproperty
  a_mode: assert property (p_mode)
    else $error("loop mode update wrong");

  property p_mdm;
    wr_loop |=> modulator_powerdown == $past(pwdata[fsc_pkg::LOOP_MDM_PD]);
  endproperty
  a_mdm: assert property (p_mdm)
    else $error("modulator power-down does not follow write");

  property p_pump;
    wr_pump |=> pump_current == $past(pwdata[7:0]);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump current code does not follow write");

  property p_rp2;
    wr_filt |=> second_pole_resistor == $past(pwdata[7:6]);
  endproperty
  a_rp2: assert property (p_rp2)
    else $error("second pole resistor code wrong");

  property p_rz;
    wr_filt |=> zero_resistor == $past(pwdata[5:3]);
  endproperty
  a_rz: assert property (p_rz)
    else $error("zero resistor code wrong");

  property p_cp1;
    wr_filt |=> first_pole_capacitor == $past(pwdata[2:0]);
  endproperty
  a_cp1: assert property (p_cp1)
    else $error("first pole capacitor code wrong");

  property p_pd_rst;
    wr_ctrl |=> synth_powerdown == $past(pwdata[fsc_pkg::CTRL_PD]) &&
      synth_reset == $past(pwdata[fsc_pkg::CTRL_RST]);
  endproperty
  a_pd_rst: assert property (p_pd_rst)
    else $error("power-down or reset bit does not follow write");

  property p_rsv;
    done && !pwrite && (hit_ctrl || hit_loop) |-> prdata[31:4] == 28'h0;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits read nonzero");

  property p_ready;
    setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready not one cycle after setup");

  property p_idle;
    !psel |=> !pready && !pslverr;
  endproperty
  a_idle: assert property (p_idle)
    else $error("answer given without a selected transfer");

  property p_err;
    done |-> pslverr == !addr_ok;
  endproperty
  a_err: assert property (p_err)
    else $error("error answer does not match address decode");

  property p_rd_clear;
    done |=> prdata == 32'h00000000;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("read data not cleared after access");

  property p_strb_drop;
    done && pwrite && !pstrb[0] |=> $stable(st.ctrl) && $stable(st.loop) &&
      $stable(st.pump) && $stable(st.filt);
  endproperty
  a_strb_drop: assert property (p_strb_drop)
    else $error("write with low strobe off changed a register");

  property p_rsv_wr;
    wr_ctrl || wr_loop |=> st.ctrl[7:4] == 4'h0 && st.loop[7:4] == 4'h0;
  endproperty
  a_rsv_wr: assert property (p_rsv_wr)
    else $error("reserved control bits were stored");

  property p_cal_count;
    cal_start |=> st.cal_count == $past(st.cal_count) + 8'h01;
  endproperty
  a_cal_count: assert property (p_cal_count)
    else $error("calibration count did not advance");

  property p_rd_pump;
    done && !pwrite && hit_pump |-> prdata == {24'h000000, pump_current};
  endproperty
  a_rd_pump: assert property (p_rd_pump)
    else $error("pump code read back wrong");

  c_cal: cover property (cal_start);
  c_rsv_mode: cover property (wr_loop && new_mode == 2'h3);
  c_err: cover property (done && pslverr);
  c_b2b: cover property (done ##2 done);
  c_stat: cover property (done && !pwrite && hit_stat);

endmodule

`default_nettype wire

//--- fsc_core_model.sv
// Behavioural stand-in for the analog loop core behind the config bank.
// Assumes cal_start is a one-cycle pulse on pclk for each calibration.
`default_nettype none

module fsc_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cal_start,
  output logic [7:0] cal_count
);
  timeunit 1ns;
  timeprecision 1ps;

  // Counts every cycle the start line is high, so a long pulse shows up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_count <= 8'h00;
    end else if (cal_start) begin
      cal_count <= cal_count + 8'h01;
    end
  end
endmodule

`default_nettype wire

//--- tb_fsc_synth_cfg.sv
// Self-checking bench for the synthesizer config bank over APB.
// Assumes the core model counts calibration pulses at the far side.
`default_nettype none

module tb_fsc_synth_cfg;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] A_CTRL = {fsc_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_LOOP = {fsc_pkg::IDX_LOOP, 2'h0};
  localparam logic [11:0] A_PUMP = {fsc_pkg::IDX_PUMP, 2'h0};
  localparam logic [11:0] A_FILT = {fsc_pkg::IDX_FILT, 2'h0};
  localparam logic [11:0] A_STAT = {fsc_pkg::IDX_STAT, 2'h0};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [fsc_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, cal_start, divider_sync, synth_powerdown, err;
  logic synth_reset, doubler_sel, modulator_powerdown;
  logic [1:0] loop_mode, second_pole_resistor, mode;
  logic [2:0] zero_resistor, first_pole_capacitor;
  logic [7:0] pump_current, cal_n, v, c;
  int n_mismatch = 0, num_checks = 0;

  fsc_synth_cfg uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cal_start(cal_start), .divider_sync(divider_sync),
    .synth_powerdown(synth_powerdown), .synth_reset(synth_reset),
    .doubler_sel(doubler_sel), .loop_mode(loop_mode),
    .modulator_powerdown(modulator_powerdown), .pump_current(pump_current),
    .second_pole_resistor(second_pole_resistor),
    .zero_resistor(zero_resistor),
    .first_pole_capacitor(first_pole_capacitor));
  fsc_core_model u_core (.pclk(pclk), .presetn(presetn),
    .cal_start(cal_start), .cal_count(cal_n));

  // Clock at 200 MHz
  always #2.5 pclk = ~pclk;

  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; result is taken at the edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // The wait ends when pready is high; only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check("pready", {31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, $urandom(), 4'hF);
    check(name, rd, exp);
  endtask

  // A reserved mode code leaves the stored mode as it was
  function automatic logic [1:0] exp_mode(input logic [1:0] old, wr);
    return (wr == 2'h3) ? old : wr;
  endfunction

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h000070A8));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    // Reset values
    rdchk("ctrl", A_CTRL, 32'h0);
    rdchk("loop", A_LOOP, 32'h1);
    check("mdm_pd", modulator_powerdown, 32'h1);
    rdchk("pump", A_PUMP, 32'h8D);
    rdchk("filt", A_FILT, 32'hE8);
    check("filt_out", {second_pole_resistor, zero_resistor,
      first_pole_capacitor}, 32'hE8);
    // Random pump and filter codes
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      apb(1'b1, A_PUMP, {24'($urandom()), v}, 4'hF);
      check("pump_out", pump_current, v);
      v = 8'($urandom());
      apb(1'b1, A_FILT, {24'($urandom()), v}, 4'hF);
      check("rp2", second_pole_resistor, v[7:6]);
      check("rz", zero_resistor, v[5:3]);
      check("cp1", first_pole_capacitor, v[2:0]);
      rdchk("filt_rd", A_FILT, v);
    end
    // Control bits with random reserved bits, calibration bit kept low
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom()) & 8'hF7;
      apb(1'b1, A_CTRL, v, 4'hF);
      check("sync", divider_sync, v[2]);
      check("pd_rst", {synth_powerdown, synth_reset}, v[1:0]);
      rdchk("ctrl_rd", A_CTRL, v & 8'h07);
    end
    // Every loop mode code, the reserved one included
    mode = 2'h0;
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom());
      v[2:1] = 2'(i);
      mode = exp_mode(mode, v[2:1]);
      apb(1'b1, A_LOOP, v, 4'hF);
      check("dbl", doubler_sel, v[3]);
      check("mode", loop_mode, mode);
      check("mdm", modulator_powerdown, v[0]);
      rdchk("loop_rd", A_LOOP, {v[3], mode, v[0]});
    end
    // Write with the low strobe off is dropped
    c = pump_current;
    apb(1'b1, A_PUMP, ~{24'h0, c}, 4'hE);
    check("pump_strb", pump_current, c);
    // Unmapped address errors and reads zero
    apb(1'b1, 12'h410, 32'hFF, 4'hF);
    check("err_wr", err, 32'h1);
    rdchk("unmapped", 12'h410, 32'h0);
    check("err_rd", err, 32'h1);
    // One calibration per rising edge of the bit, none while held
    c = cal_n;
    apb(1'b1, A_CTRL, 32'h8, 4'hF);
    apb(1'b1, A_CTRL, 32'h8, 4'hF);
    repeat (4) @(negedge pclk);
    check("cal_once", cal_n, c + 8'h01);
    apb(1'b1, A_CTRL, 32'h0, 4'hF);
    apb(1'b1, A_CTRL, 32'h8, 4'hF);
    repeat (4) @(negedge pclk);
    check("cal_again", cal_n, c + 8'h02);
    // Status ignores writes and counts both starts since reset
    apb(1'b1, A_STAT, 32'hFF, 4'hF);
    check("err_stat", err, 32'h0);
    rdchk("stat", A_STAT, 32'h2);
    // Reset in mid-run brings the defaults back
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("sync_rst", divider_sync, 32'h0);
    check("pd_rst0", {synth_powerdown, synth_reset}, 32'h0);
    check("mode_rst", loop_mode, 32'h0);
    check("mdm_rst", modulator_powerdown, 32'h1);
    check("pump_rst", pump_current, 32'h8D);
    check("cal_rst", cal_n, 32'h0);
    rdchk("stat_rst", A_STAT, 32'h0);
    end_sim();
  end
endmodule

`default_nettype wire
